// [testbench/pcr_host_model.sv]
// serial host model that frames register writes and reads
`timescale 1ns/1ps
`default_nettype none

module pcr_host_model (
  // clock
  input  wire logic clk,
  // serial port toward the register bank
  output logic      sen,
  output logic      sclk,
  output logic      sdi,
  input  wire logic sdo_wire
);
  // port idles with the serial clock standing low
  initial begin
    sen  = 1'b0;
    sclk = 1'b0;
    sdi  = 1'b0;
  end

  // flag, address, data msb first; fewer than 31 rises aborts the frame
  task automatic xfer(input logic rw, input logic [5:0] addr,
                      input logic [23:0] data, input int nrise,
                      output logic [23:0] rdata);
    logic [30:0] bits;
    bits  = {rw, addr, data};
    rdata = 24'h000000;
    @(negedge clk);
    sen <= 1'b1;
    sdi <= bits[30];
    for (int i = 0; i < nrise; i++) begin
      @(negedge clk);
      sclk <= 1'b1;
      @(negedge clk);
      if (i >= 7) rdata[30 - i] = sdo_wire;
      sclk <= 1'b0;
      if (i < 30) sdi <= bits[29 - i];
    end
    @(negedge clk);
    sen <= 1'b0;
    sdi <= ~sdi; // released line shows the inverse of its last level
    @(negedge clk);
  endtask
endmodule
`default_nettype wire

// [testbench/pll_core_config_registers_tb_top.sv]
// self-checking bench of the synthesizer setup register bank
`timescale 1ns/1ps
`default_nettype none

module pll_core_config_registers_tb_top;
  typedef struct packed {
    logic [5:0]  addr;
    logic [23:0] data;
    logic        rd;
    logic [23:0] rexp;
  } pcr_row_t;

  // ratio is never written as zero by these rows
  // columns: address, written word, read back, expected read word
  localparam pcr_row_t ROWS [23] = '{
    '{6'h01, 24'h00FFFD, 1'b1, 24'h00FFFD},
    '{6'h01, 24'hFFFFFF, 1'b1, 24'h00FFFF},
    '{6'h03, 24'hFD4005, 1'b1, 24'h014005},
    '{6'h03, 24'h000005, 1'b1, 24'h000005},
    '{6'h03, 24'h008001, 1'b1, 24'h008001},
    '{6'h03, 24'h00C001, 1'b1, 24'h00C001},
    '{6'h03, 24'h008002, 1'b1, 24'h008002},
    '{6'h03, 24'h00BFFF, 1'b1, 24'h00BFFF},
    '{6'h01, 24'h00EFFB, 1'b1, 24'h00EFFB},
    '{6'h04, 24'hFFFFFF, 1'b1, 24'h000001},
    '{6'h04, 24'h000000, 1'b1, 24'h000000},
    '{6'h05, 24'h000001, 1'b1, 24'h000001},
    '{6'h05, 24'hFFFFFE, 1'b1, 24'h000006},
    '{6'h06, 24'h000001, 1'b1, 24'h000001},
    '{6'h06, 24'hFFFFFF, 1'b1, 24'h000007},
    '{6'h07, 24'h0003E0, 1'b1, 24'h0003E0},
    '{6'h07, 24'hFFFC1F, 1'b1, 24'h00001F},
    '{6'h08, 24'h123456, 1'b1, 24'h000000},
    '{6'h3F, 24'hABCDEF, 1'b1, 24'h000000},
    '{6'h02, 24'h000000, 1'b1, 24'h000000},
    '{6'h02, 24'h000001, 1'b1, 24'h000001},
    '{6'h02, 24'h000002, 1'b0, 24'h000002},
    '{6'h02, 24'h000003, 1'b1, 24'h000003}};

  logic        clk, sys_rst;
  wire         sen, sclk, sdi, sdo_wire;
  logic        pin_o, pin_oe_n, bias_on, vco_buffer_on, prescaler_bias_on;
  logic        prescaler_long_low, ref_div_run, ref_use_divider;
  logic        ref_sine_select, square_buffer_on, sine_buffer_on;
  logic        mod_clk_from_vco, modulator_run, lock_detect_run;
  logic        lock_detect_dig_on, cycle_slip_prevention, pd_invert;
  logic        pd_up_pass, pd_down_pass, pump_output_on;
  logic [5:0]  prescaler_low_cycles;
  logic [13:0] ref_div_ratio;
  logic [3:0]  ref_clk_gates;
  logic [2:0]  pd_delay_sel;
  logic [4:0]  pump_up_current, pump_down_current;
  logic [55:0] got_v;
  logic [15:0] m_blk;
  logic [16:0] m_rp;
  logic [9:0]  m_pump;
  logic [2:0]  m_pfd, m_pdel;
  logic [1:0]  m_drv;
  logic        m_presc;
  logic        last_pin;
  int          errors, total_checks;

  // pin level seen by the host: a released pin shows the inverse of the
  // last driven level, so a late driver enable corrupts the read
  always @(negedge clk) begin
    if (!pin_oe_n) last_pin <= pin_o;
  end
  assign sdo_wire = pin_oe_n ? ~last_pin : pin_o;
  assign got_v = {pin_oe_n, bias_on, vco_buffer_on, prescaler_bias_on,
    prescaler_long_low, prescaler_low_cycles, ref_div_run, ref_use_divider,
    ref_div_ratio, ref_sine_select, square_buffer_on, sine_buffer_on,
    ref_clk_gates, mod_clk_from_vco, modulator_run, lock_detect_run,
    lock_detect_dig_on, cycle_slip_prevention, pd_invert, pd_up_pass,
    pd_down_pass, pd_delay_sel, pump_output_on, pump_up_current,
    pump_down_current};

  pcr_config_regs DUT (.clk(clk), .sys_rst(sys_rst), .sen(sen),
    .sclk(sclk), .sdi(sdi), .lock_or_serial_out_pin_o(pin_o),
    .lock_or_serial_out_pin_oe_n(pin_oe_n), .bias_on(bias_on),
    .vco_buffer_on(vco_buffer_on), .prescaler_bias_on(prescaler_bias_on),
    .prescaler_long_low(prescaler_long_low),
    .prescaler_low_cycles(prescaler_low_cycles), .ref_div_run(ref_div_run),
    .ref_use_divider(ref_use_divider), .ref_div_ratio(ref_div_ratio),
    .ref_sine_select(ref_sine_select), .square_buffer_on(square_buffer_on),
    .sine_buffer_on(sine_buffer_on), .ref_clk_gates(ref_clk_gates),
    .mod_clk_from_vco(mod_clk_from_vco), .modulator_run(modulator_run),
    .lock_detect_run(lock_detect_run),
    .lock_detect_dig_on(lock_detect_dig_on),
    .cycle_slip_prevention(cycle_slip_prevention), .pd_invert(pd_invert),
    .pd_up_pass(pd_up_pass), .pd_down_pass(pd_down_pass),
    .pd_delay_sel(pd_delay_sel), .pump_output_on(pump_output_on),
    .pump_up_current(pump_up_current),
    .pump_down_current(pump_down_current));

  pcr_host_model host (.clk(clk), .sen(sen), .sclk(sclk), .sdi(sdi),
    .sdo_wire(sdo_wire));

  // register defaults of the bank
  task automatic model_reset();
    m_blk   = 16'hFE9B;
    m_drv   = 2'h3;
    m_rp    = 17'h08001;
    m_presc = 1'b0;
    m_pfd   = 3'h6;
    m_pdel  = 3'h2;
    m_pump  = 10'h210;
  endtask

  // stored fields keep only their defined low bits
  task automatic model_write(input logic [5:0] a, input logic [23:0] d);
    case (a)
      6'h00: if (d[0]) model_reset();
      6'h01: m_blk = d[15:0];
      6'h02: m_drv = d[1:0];
      6'h03: m_rp = d[16:0];
      6'h04: m_presc = d[0];
      6'h05: m_pfd = d[2:0];
      6'h06: m_pdel = d[2:0];
      6'h07: m_pump = d[9:0];
      default: ;
    endcase
  endtask

  // readback with undefined bits and unmapped places as zero
  function automatic logic [23:0] model_read(input logic [5:0] a);
    case (a)
      6'h01: return {8'h00, m_blk};
      6'h02: return {22'h000000, m_drv};
      6'h03: return {7'h00, m_rp};
      6'h04: return {23'h000000, m_presc};
      6'h05: return {21'h000000, m_pfd};
      6'h06: return {21'h000000, m_pdel};
      6'h07: return {14'h0000, m_pump};
      default: return 24'h000000;
    endcase
  endfunction

  // expected control outputs, loop enables gated by bias
  function automatic logic [55:0] exp_out();
    logic b;
    logic run;
    b   = m_blk[1];
    run = b & m_blk[2];
    return {(m_drv[1] ? ~m_drv[0] : 1'b1), b, b & m_blk[0], b & m_blk[10],
      m_presc, (m_presc ? 6'h2F : 6'h0F), run,
      run & (m_rp[15] ? (m_rp[13:0] != 14'h0001) : m_rp[14]),
      m_rp[13:0], m_rp[16], b & m_blk[7] & ~m_rp[16],
      b & m_blk[8] & m_rp[16], {4{b}} & m_blk[6:3], m_blk[9],
      b & m_blk[13], b & m_blk[14], b & m_blk[11], b & m_blk[15], m_pfd[0],
      b & m_pfd[1], b & m_pfd[2], m_pdel, b & m_blk[12], m_pump[4:0],
      m_pump[9:5]};
  endfunction

  // compare and count
  task automatic check(input logic [55:0] g, input logic [55:0] e);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // register write through the serial port
  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    logic [23:0] r;
    host.xfer(1'b0, a, d, 31, r);
    model_write(a, d);
  endtask

  // register read compared against an expected word
  task automatic rd_exp(input logic [5:0] a, input logic [23:0] e);
    logic [23:0] r;
    host.xfer(1'b1, a, 24'h000000, 31, r);
    check({32'h0, r}, {32'h0, e});
  endtask

  // register read compared against the model
  task automatic rd_check(input logic [5:0] a);
    rd_exp(a, model_read(a));
  endtask

  // outputs once the port is idle again
  task automatic check_out();
    @(negedge clk);
    check(got_v, exp_out());
  endtask

  // outputs and every address 0 to 8
  task automatic check_all();
    check_out();
    for (int a = 0; a < 9; a++) rd_check(a[5:0]);
  endtask

  task automatic complete_run();
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // free-running 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // hang guard
  initial begin
    #2000000;
    errors++;
    complete_run();
  end

  // main sequence
  initial begin
    logic [23:0] r;
    errors = 0;
    total_checks = 0;
    sys_rst = 1'b1;
    model_reset();
    repeat (8) @(negedge clk);
    sys_rst <= 1'b0;
    check_all();
    foreach (ROWS[i]) begin
      wr(ROWS[i].addr, ROWS[i].data);
      check_out();
      if (ROWS[i].rd) rd_exp(ROWS[i].addr, ROWS[i].rexp);
    end
    // aborted frame leaves the pump codes untouched
    host.xfer(1'b0, 6'h07, 24'h00015A, 15, r);
    check_out();
    rd_check(6'h07);
    // strobe with bit 0 clear does nothing, set restores defaults
    wr(6'h00, 24'hFFFFFE);
    check_out();
    wr(6'h00, 24'h000001);
    check_all();
    // reset in mid-run
    wr(6'h05, 24'h000001);
    @(negedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(negedge clk);
    sys_rst <= 1'b0;
    model_reset();
    check_all();
    complete_run();
  end
endmodule
`default_nettype wire

// [verilog/pcr_config_regs.sv]
// serial-programmed configuration register bank of the synthesizer loop
// Overview of operation
// (R01) bias bit low disables whole loop
// (R02) divider enable low holds divider reset
// (R03) bit 9 picks modulator clock source
// (R04) pump enable low tristates pump output
// (R05) modulator runs only while bit 13 set
// (R06) lock detect runs only while bit 14
// (R07) bit 15 enables cycle slip prevention
// (R08) bit 11 enables digital lock detect gating
// (R09) bits 3-6 gate reference clocks to logic
// (R10) buffer enables qualified by sine select
// (R11) force bit makes driver follow value
// (R12) otherwise driver on only during reads
// (R13) 14-bit ratio divides when enabled, selected
// (R14) software keeps ratio nonzero, two upward
// (R15) select bit routes through or bypasses
// (R16) auto mode bypasses only at ratio one
// (R17) bit 16 selects sine reference input
// (R18) duty bit stretches prescaler low time
// (R19) bit 0 inverts phase detector polarity
// (R20) bits 1,2 mask up/down detector outputs
// (R21) 3-bit delay setpoint for detector reset
// (R22) two 5-bit pump current codes
// (R23) frame: flag, six address, 24 data
// (R24) strobe bit returns registers to default
// (R25) undefined bits ignored, read as zero
`timescale 1ns/1ps
`default_nettype none
`include "pcr_defs.svh"

module pcr_config_regs (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // four-wire serial port
  input  wire logic       sen,
  input  wire logic       sclk,
  input  wire logic       sdi,
  output logic            lock_or_serial_out_pin_o,
  output logic            lock_or_serial_out_pin_oe_n,
  // bias, oscillator and prescaler controls
  output logic            bias_on,
  output logic            vco_buffer_on,
  output logic            prescaler_bias_on,
  output logic            prescaler_long_low,
  output logic [5:0]      prescaler_low_cycles,
  // reference path controls
  output logic            ref_div_run,
  output logic            ref_use_divider,
  output logic [13:0]     ref_div_ratio,
  output logic            ref_sine_select,
  output logic            square_buffer_on,
  output logic            sine_buffer_on,
  output logic [3:0]      ref_clk_gates,
  // modulator, lock detect and phase detector controls
  output logic            mod_clk_from_vco,
  output logic            modulator_run,
  output logic            lock_detect_run,
  output logic            lock_detect_dig_on,
  output logic            cycle_slip_prevention,
  output logic            pd_invert,
  output logic            pd_up_pass,
  output logic            pd_down_pass,
  output logic [2:0]      pd_delay_sel,
  // charge pump controls
  output logic            pump_output_on,
  output logic [4:0]      pump_up_current,
  output logic [4:0]      pump_down_current
);

  localparam pcr_pkg::pcr_state_t RST_STATE = '{
    sclk_q:   1'b0,
    bit_cnt:  6'h00,
    rw:       1'b0,
    read_act: 1'b0,
    addr:     6'h00,
    wdata:    24'h000000,
    out_sr:   24'h000000,
    sdo:      1'b0,
    blk:      `PCR_RST_BLOCK,
    drv:      `PCR_RST_DRIVE,
    rpath:    `PCR_RST_REFPATH,
    pdut:     `PCR_RST_PRESC,
    pfd:      `PCR_RST_PFD,
    pdel:     `PCR_RST_PFDDEL,
    pump:     `PCR_RST_PUMP
  };

  pcr_pkg::pcr_state_t s_ff;
  pcr_pkg::pcr_state_t nxt_s;
  logic                sclk_rise;
  logic [23:0]         frame_word;

  // read-back word of one register, undefined bits zero
  function automatic logic [23:0] read_word(
    input logic [5:0]          a,
    input pcr_pkg::pcr_state_t st
  );
    logic [23:0] w;
    w = 24'h000000;
    unique case (a)
      `PCR_ADDR_BLOCK:   w = {8'h00, st.blk};   // R25
      `PCR_ADDR_DRIVE:   w = {22'h000000, st.drv};
      `PCR_ADDR_REFPATH: w = {7'h00, st.rpath};
      `PCR_ADDR_PRESC:   w = {23'h000000, st.pdut};
      `PCR_ADDR_PFD:     w = {21'h000000, st.pfd};
      `PCR_ADDR_PFDDEL:  w = {21'h000000, st.pdel};
      `PCR_ADDR_PUMP:    w = {14'h0000, st.pump};
      default:           w = 24'h000000;
    endcase
    return w;
  endfunction

  // inputs are synchronous, so an edge is seen against the last sample
  assign sclk_rise  = sclk & ~s_ff.sclk_q;
  assign frame_word = {s_ff.wdata[22:0], sdi};

  // serial frame decode and register updates
  always_comb begin
    nxt_s        = s_ff;
    nxt_s.sclk_q = sclk;
    if (!sen) begin
      // frame ends whenever the enable drops
      nxt_s.bit_cnt  = 6'h00;
      nxt_s.read_act = 1'b0;
    end else if (sclk_rise) begin
      if (s_ff.bit_cnt != `PCR_CNT_DONE) begin
        nxt_s.bit_cnt = s_ff.bit_cnt + 6'h01;
      end
      // first edge: read/write flag
      if (s_ff.bit_cnt == `PCR_CNT_FLAG) begin
        nxt_s.rw       = sdi;                              // R23
        nxt_s.read_act = sdi;                              // R12
      end else if (s_ff.bit_cnt <= `PCR_CNT_ADDR_LAST) begin
        nxt_s.addr = {s_ff.addr[4:0], sdi};                // R23
      end else if (s_ff.bit_cnt <= `PCR_CNT_DATA_LAST) begin
        nxt_s.wdata = frame_word;                          // R23
      end
      // address complete: fetch the read word
      if (s_ff.bit_cnt == `PCR_CNT_ADDR_LAST) begin
        nxt_s.out_sr = read_word({s_ff.addr[4:0], sdi}, s_ff);
      end
      // read data leaves msb first, one bit per rising edge
      if (s_ff.rw && s_ff.bit_cnt >= `PCR_CNT_DATA_1ST &&
          s_ff.bit_cnt <= `PCR_CNT_DATA_LAST) begin
        nxt_s.sdo    = s_ff.out_sr[23];                    // R23
        nxt_s.out_sr = {s_ff.out_sr[22:0], 1'b0};
      end
      // last data bit of a write frame commits the word
      if (!s_ff.rw && s_ff.bit_cnt == `PCR_CNT_DATA_LAST) begin
        unique case (s_ff.addr)
          `PCR_ADDR_STROBE: begin
            if (frame_word[`PCR_STR_SWRST]) begin
              nxt_s.blk   = `PCR_RST_BLOCK;                // R24
              nxt_s.drv   = `PCR_RST_DRIVE;
              nxt_s.rpath = `PCR_RST_REFPATH;
              nxt_s.pdut  = `PCR_RST_PRESC;
              nxt_s.pfd   = `PCR_RST_PFD;
              nxt_s.pdel  = `PCR_RST_PFDDEL;
              nxt_s.pump  = `PCR_RST_PUMP;
            end
          end
          `PCR_ADDR_BLOCK:   nxt_s.blk   = frame_word[15:0]; // R25
          `PCR_ADDR_DRIVE:   nxt_s.drv   = frame_word[1:0];
          `PCR_ADDR_REFPATH: nxt_s.rpath = frame_word[16:0];
          `PCR_ADDR_PRESC:   nxt_s.pdut  = frame_word[0];
          `PCR_ADDR_PFD:     nxt_s.pfd   = frame_word[2:0];
          `PCR_ADDR_PFDDEL:  nxt_s.pdel  = frame_word[2:0];
          `PCR_ADDR_PUMP:    nxt_s.pump  = frame_word[9:0];
          default: begin
          end
        endcase
      end
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_ff <= RST_STATE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // output pin driver: forced, else only during a read
  always_comb begin
    lock_or_serial_out_pin_o = s_ff.sdo;
    if (s_ff.drv[`PCR_DRV_FORCE]) begin
      lock_or_serial_out_pin_oe_n = ~s_ff.drv[`PCR_DRV_VAL];   // R11
    end else begin
      lock_or_serial_out_pin_oe_n = ~s_ff.read_act;            // R12
    end
  end

  // bias gates every loop block
  assign bias_on            = s_ff.blk[`PCR_BLK_BIAS];                // R01
  assign vco_buffer_on      = bias_on & s_ff.blk[`PCR_BLK_VCOBUF];
  assign prescaler_bias_on  = bias_on & s_ff.blk[`PCR_BLK_PRESC];
  assign prescaler_long_low = s_ff.pdut;                              // R18
  assign prescaler_low_cycles = s_ff.pdut ? `PCR_PRESC_LOW_LONG :
                                            `PCR_PRESC_LOW_SHORT;     // R18

  // reference divider: held in reset means bypassed
  assign ref_div_run     = bias_on & s_ff.blk[`PCR_BLK_RDIV_EN];      // R02
  assign ref_div_ratio   = s_ff.rpath[`PCR_RP_RATIO_HI:0];            // R13
  assign ref_use_divider = ref_div_run &
    (s_ff.rpath[`PCR_RP_AUTO] ? (ref_div_ratio != `PCR_RATIO_ONE)     // R16
                              : s_ff.rpath[`PCR_RP_SEL]);             // R15
  assign ref_sine_select = s_ff.rpath[`PCR_RP_SIN];                   // R17
  assign square_buffer_on = bias_on & s_ff.blk[`PCR_BLK_SQ_BUF] &
                            ~ref_sine_select;                         // R10
  assign sine_buffer_on   = bias_on & s_ff.blk[`PCR_BLK_SIN_BUF] &
                            ref_sine_select;                          // R10
  // reference clock gates: sine, square, divided, muxed
  assign ref_clk_gates = {4{bias_on}} &
                         s_ff.blk[`PCR_BLK_SIN_CLK:`PCR_BLK_XMUX_CLK]; // R09

  // modulator, lock detect and phase detector
  assign mod_clk_from_vco   = s_ff.blk[`PCR_BLK_MOD_CLK];             // R03
  assign modulator_run      = bias_on & s_ff.blk[`PCR_BLK_MOD_RUN];   // R05
  assign lock_detect_run    = bias_on & s_ff.blk[`PCR_BLK_LKD_RUN];   // R06
  assign lock_detect_dig_on = bias_on & s_ff.blk[`PCR_BLK_LKD_DIG];   // R08
  assign cycle_slip_prevention = bias_on & s_ff.blk[`PCR_BLK_CSP];    // R07
  assign pd_invert    = s_ff.pfd[`PCR_PFD_INV];                       // R19
  assign pd_up_pass   = bias_on & s_ff.pfd[`PCR_PFD_UP];              // R20
  assign pd_down_pass = bias_on & s_ff.pfd[`PCR_PFD_DN];              // R20
  assign pd_delay_sel = s_ff.pdel;                                    // R21

  // charge pump: disabled output is high impedance in the analog
  assign pump_output_on    = bias_on & s_ff.blk[`PCR_BLK_PUMP];       // R04
  assign pump_up_current   = s_ff.pump[`PCR_PUMP_UP_HI:0];            // R22
  assign pump_down_current = s_ff.pump[9:`PCR_PUMP_DN_LO];            // R22

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_read_flag;
    sen && sclk_rise && s_ff.bit_cnt == `PCR_CNT_FLAG && sdi;
  endsequence

  sequence s_write_last;
    sen && sclk_rise && !s_ff.rw && s_ff.bit_cnt == `PCR_CNT_DATA_LAST;
  endsequence

  property p_bias_off;
    !s_ff.blk[`PCR_BLK_BIAS] |->
      !pump_output_on && !modulator_run && !lock_detect_run;
  endproperty
  a_bias_off: assert property (p_bias_off) // R01
    else $error("loop block active with bias off");

  property p_refdiv_hold;
    !s_ff.blk[`PCR_BLK_RDIV_EN] |-> !ref_div_run && !ref_use_divider;
  endproperty
  a_refdiv_hold: assert property (p_refdiv_hold) // R02
    else $error("reference divider used while held");

  property p_auto_sel;
    ref_div_run && s_ff.rpath[`PCR_RP_AUTO] |->
      ref_use_divider == (s_ff.rpath[13:0] != 14'h0001);
  endproperty
  a_auto_sel: assert property (p_auto_sel) // R16
    else $error("automatic divider select wrong");

  property p_manual_sel;
    ref_div_run && !s_ff.rpath[`PCR_RP_AUTO] |->
      ref_use_divider == s_ff.rpath[`PCR_RP_SEL];
  endproperty
  a_manual_sel: assert property (p_manual_sel) // R15
    else $error("manual divider select wrong");

  property p_buf_sel;
    (square_buffer_on |-> !s_ff.rpath[16]) and
    (sine_buffer_on |-> s_ff.rpath[16]);
  endproperty
  a_buf_sel: assert property (p_buf_sel) // R10
    else $error("reference buffer on against sine select");

  property p_force_drv;
    s_ff.drv[`PCR_DRV_FORCE] |->
      lock_or_serial_out_pin_oe_n == !s_ff.drv[`PCR_DRV_VAL];
  endproperty
  a_force_drv: assert property (p_force_drv) // R11
    else $error("forced driver enable not followed");

  property p_read_drv;
    s_read_flag ##0 !s_ff.drv[`PCR_DRV_FORCE] |=>
      !lock_or_serial_out_pin_oe_n;
  endproperty
  a_read_drv: assert property (p_read_drv) // R12
    else $error("driver off during read");

  property p_idle_hiz;
    !sen && !s_ff.drv[`PCR_DRV_FORCE] |=>
      s_ff.drv[`PCR_DRV_FORCE] || lock_or_serial_out_pin_oe_n;
  endproperty
  a_idle_hiz: assert property (p_idle_hiz) // R12
    else $error("driver on outside a read");

  property p_pump_write;
    s_write_last ##0 s_ff.addr == `PCR_ADDR_PUMP |=>
      pump_down_current == $past(s_ff.wdata[8:4]);
  endproperty
  a_pump_write: assert property (p_pump_write) // R23
    else $error("pump write not committed");

  property p_soft_reset;
    s_write_last ##0 s_ff.addr == `PCR_ADDR_STROBE ##0 sdi |=>
      s_ff.blk == `PCR_RST_BLOCK && s_ff.pump == `PCR_RST_PUMP;
  endproperty
  a_soft_reset: assert property (p_soft_reset) // R24
    else $error("soft reset did not restore defaults");

  property p_sdo_first;
    sen && sclk_rise && s_ff.rw && s_ff.bit_cnt == `PCR_CNT_DATA_1ST |=>
      lock_or_serial_out_pin_o == $past(s_ff.out_sr[23]);
  endproperty
  a_sdo_first: assert property (p_sdo_first) // R23
    else $error("first read bit not presented");

  // only the last data bit of a write frame may change a register
  property p_regs_hold;
    !(sen && sclk_rise && !s_ff.rw &&
      s_ff.bit_cnt == `PCR_CNT_DATA_LAST) |=>
      $stable(s_ff.blk) && $stable(s_ff.drv) && $stable(s_ff.rpath) &&
      $stable(s_ff.pdut) && $stable(s_ff.pfd) && $stable(s_ff.pdel) &&
      $stable(s_ff.pump);
  endproperty
  a_regs_hold: assert property (p_regs_hold) // R23
    else $error("register changed without a committed write");

  property p_pump_off;
    !s_ff.blk[`PCR_BLK_PUMP] |-> !pump_output_on;
  endproperty
  a_pump_off: assert property (p_pump_off) // R04
    else $error("pump output on while disabled");

  // a dropped enable always restarts the frame
  property p_frame_end;
    !sen |=> s_ff.bit_cnt == 6'h00 && !s_ff.read_act;
  endproperty
  a_frame_end: assert property (p_frame_end) // R23
    else $error("frame state kept after enable dropped");

endmodule
`default_nettype wire

// [verilog/pcr_defs.svh]
// offsets, field positions, reset values and counts of the synthesizer setup
`ifndef PCR_DEFS_SVH
`define PCR_DEFS_SVH

// register addresses carried in the serial frame
`define PCR_ADDR_STROBE   6'h00
`define PCR_ADDR_BLOCK    6'h01
`define PCR_ADDR_DRIVE    6'h02
`define PCR_ADDR_REFPATH  6'h03
`define PCR_ADDR_PRESC    6'h04
`define PCR_ADDR_PFD      6'h05
`define PCR_ADDR_PFDDEL   6'h06
`define PCR_ADDR_PUMP     6'h07

// reset values of the stored fields
`define PCR_RST_BLOCK     16'hFE9B
`define PCR_RST_DRIVE     2'h3
`define PCR_RST_REFPATH   17'h08001
`define PCR_RST_PRESC     1'h0
`define PCR_RST_PFD       3'h6
`define PCR_RST_PFDDEL    3'h2
`define PCR_RST_PUMP      10'h210

// block enable field positions
`define PCR_BLK_VCOBUF    0
`define PCR_BLK_BIAS      1
`define PCR_BLK_RDIV_EN   2
`define PCR_BLK_XMUX_CLK  3
`define PCR_BLK_RDIV_CLK  4
`define PCR_BLK_SQ_CLK    5
`define PCR_BLK_SIN_CLK   6
`define PCR_BLK_SQ_BUF    7
`define PCR_BLK_SIN_BUF   8
`define PCR_BLK_MOD_CLK   9
`define PCR_BLK_PRESC     10
`define PCR_BLK_LKD_DIG   11
`define PCR_BLK_PUMP      12
`define PCR_BLK_MOD_RUN   13
`define PCR_BLK_LKD_RUN   14
`define PCR_BLK_CSP       15

// output driver force, reference path, phase detector, pump fields
`define PCR_DRV_VAL       0
`define PCR_DRV_FORCE     1
`define PCR_RP_RATIO_HI   13
`define PCR_RP_SEL        14
`define PCR_RP_AUTO       15
`define PCR_RP_SIN        16
`define PCR_RATIO_ONE     14'h0001
`define PCR_PFD_INV       0
`define PCR_PFD_UP        1
`define PCR_PFD_DN        2
`define PCR_PUMP_UP_HI    4
`define PCR_PUMP_DN_LO    5
`define PCR_STR_SWRST     0

// prescaler low time in oscillator cycles
`define PCR_PRESC_LOW_SHORT 6'h0F
`define PCR_PRESC_LOW_LONG  6'h2F

// serial frame bit counts (count before the current rising edge)
`define PCR_CNT_FLAG      6'h00
`define PCR_CNT_ADDR_LAST 6'h06
`define PCR_CNT_DATA_1ST  6'h07
`define PCR_CNT_DATA_LAST 6'h1E
`define PCR_CNT_DONE      6'h1F

`endif

// [verilog/pcr_pkg.sv]
// types of the synthesizer setup register bank
package pcr_pkg;

  // whole state of the register bank and its serial port
  typedef struct packed {
    logic        sclk_q;
    logic [5:0]  bit_cnt;
    logic        rw;
    logic        read_act;
    logic [5:0]  addr;
    logic [23:0] wdata;
    logic [23:0] out_sr;
    logic        sdo;
    logic [15:0] blk;
    logic [1:0]  drv;
    logic [16:0] rpath;
    logic        pdut;
    logic [2:0]  pfd;
    logic [2:0]  pdel;
    logic [9:0]  pump;
  } pcr_state_t;

endpackage
